// *** hw/ais_map.vh ***
/*
  Constants for the analog input scaling path: register offsets, field
  positions, reset values and the fixed-point format of the gains.
  Assumes it is included by bare name from the design files.
*/
// Function
// - Samples are 12-bit unsigned, 4095 steps
// - Default output is two's complement 16-bit
// - Feature register selects alternative output formats
// - Zero-based variant: 0, 0x3fff, 0x7fff mapping
// - Live-zero variant: 4 mA gives zero
// - No scaling: output (offset plus sample) times gain
// - Vendor scaling only: offset plus gain times value
// - User scaling only: user line on compensated value
// - Both: user line applied after vendor line
// - Feature register enables each scaling stage
// - Each coefficient has its own register
// - One 16-bit word, 8-bit status per channel
`ifndef AIS_MAP_VH
`define AIS_MAP_VH

// Channel count and widths
`define AIS_NCH 8
`define AIS_CHW 3
`define AIS_ADCW 12
`define AIS_DW 16
`define AIS_STW 8
`define AIS_AW 6

// Gains are signed with this many fraction bits (0x0800 is 1.0)
`define AIS_FRAC 11

// Register offsets
`define AIS_OFS_STATUS 6'h01
`define AIS_OFS_COMP_OFS 6'h11
`define AIS_OFS_COMP_GAIN 6'h12
`define AIS_OFS_VSC_OFS 6'h13
`define AIS_OFS_VSC_GAIN 6'h14
`define AIS_OFS_FEATURE 6'h20
`define AIS_OFS_USC_OFS 6'h21
`define AIS_OFS_USC_GAIN 6'h22

// Feature register fields
`define AIS_FEAT_VEN 0
`define AIS_FEAT_UEN 1
`define AIS_FEAT_FMT_LO 2
`define AIS_FEAT_FMT_HI 3

// Output formats
`define AIS_FMT_TWOS 2'h0
`define AIS_FMT_SIGNMAG 2'h1
`define AIS_FMT_ALT 2'h2

// Datapath operation codes
`define AIS_OP_PASS 2'h0
`define AIS_OP_PRE 2'h1
`define AIS_OP_POST 2'h2

// Reset values
`define AIS_RST_FEATURE 16'h0001
`define AIS_RST_COMP_OFS 16'h0000
`define AIS_RST_GAIN_ONE 16'h0800
`define AIS_RST_VSC_OFS_ZB 16'h0000
`define AIS_RST_VSC_GAIN_ZB 16'h4004
`define AIS_RST_VSC_OFS_LZ 16'he000
`define AIS_RST_VSC_GAIN_LZ 16'h5004
`define AIS_RST_USC_OFS 16'h0000

`endif

// *** hw/ais_mac.v ***
/*
  Straight-line arithmetic stage: pass, (b + x) * a or b + a * x, with
  saturation to signed 16 bits and a registered result.
  Assumes ais_map.vh constants and one clock with async low reset.
*/
`include "ais_map.vh"
`default_nettype none

module ais_mac (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Operands
  input wire [1:0] op_i,
  input wire signed [15:0] x_i,
  input wire signed [15:0] a_i,
  input wire signed [15:0] b_i,
  // Result
  output reg signed [15:0] y_o,
  output reg sat_o
);

  reg signed [33:0] wide; // Full-precision result before clamping
  reg signed [16:0] sum; // Offset plus sample for pre-add form

  // Combinational line equation
  always @* begin
    sum = {b_i[15], b_i} + {x_i[15], x_i};
    case (op_i)
      `AIS_OP_PRE: wide = (sum * a_i) >>> `AIS_FRAC;
      `AIS_OP_POST: wide = ((x_i * a_i) >>> `AIS_FRAC) + b_i;
      default: wide = {{18{x_i[15]}}, x_i};
    endcase
  end

  // Clamp instead of wrapping; the per-result flag, set again on every edge, feeds channel status
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      y_o <= 16'sh0000;
      sat_o <= 1'b0;
    end else if (wide > 34'sh0_0000_7fff) begin
      y_o <= 16'sh7fff;
      sat_o <= 1'b1;
    end else if (wide < -34'sh0_0000_8000) begin
      y_o <= 16'sh8000;
      sat_o <= 1'b1;
    end else begin
      y_o <= wide[15:0];
      sat_o <= 1'b0;
    end
  end

endmodule // ais_mac

`default_nettype wire

// *** hw/ais_ram.v ***
/*
  Per-channel process data store: one write port from the datapath, one
  read port for the coupler, read data held in a register.
  Assumes a single clock; a write and a read of one channel in the same
  cycle returns the old word.
*/
`include "ais_map.vh"
`default_nettype none

module ais_ram (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Write port
  input wire wr_i,
  input wire [`AIS_CHW-1:0] wr_ch_i,
  input wire [`AIS_DW+`AIS_STW-1:0] wr_word_i,
  // Read port
  input wire rd_i,
  input wire [`AIS_CHW-1:0] rd_ch_i,
  output reg [`AIS_DW+`AIS_STW-1:0] rd_word_o
);

  reg [`AIS_DW+`AIS_STW-1:0] mem [0:`AIS_NCH-1]; // Status byte above data word

  // Whole word written in one edge so the coupler never sees a half update
  always @(posedge ref_clk_i) begin
    if (wr_i) begin
      mem[wr_ch_i] <= wr_word_i;
    end
  end

  // Registered read
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_word_o <= 24'h000000;
    end else if (rd_i) begin
      rd_word_o <= mem[rd_ch_i];
    end
  end

endmodule // ais_ram

`default_nettype wire

// *** hw/ais_core.v ***
/*
  Analog input scaling path top: accepts converter samples, runs them
  through compensation, vendor and user straight-line scaling on one
  shared stage, formats the result and stores it per channel.
  Assumes samples and register strobes are synchronous to ref_clk_i and
  that the converter holds a sample until it is taken.
*/
`include "ais_map.vh"
`default_nettype none

module ais_core #(
  parameter LIVE_ZERO = 0 // 1 selects the 4 to 20 mA reset scaling
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Converter samples
  input wire samp_valid_i,
  input wire [`AIS_CHW-1:0] samp_ch_i,
  input wire [`AIS_ADCW-1:0] samp_data_i,
  output reg samp_ready_o,
  // Coupler process data read
  input wire pd_rd_i,
  input wire [`AIS_CHW-1:0] pd_ch_i,
  output wire [`AIS_DW-1:0] pd_data_o,
  output wire [`AIS_STW-1:0] pd_status_o,
  // Register port
  input wire [`AIS_AW-1:0] reg_addr_i,
  input wire [`AIS_DW-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [`AIS_DW-1:0] reg_rdata_o
);

  // One-hot sequencer states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_COMP = 5'h02;
  localparam [4:0] ST_VEND = 5'h04;
  localparam [4:0] ST_USER = 5'h08;
  localparam [4:0] ST_WR = 5'h10;

  // Reset values that depend on the current-range variant
  localparam [15:0] VSC_OFS_RST = LIVE_ZERO ? `AIS_RST_VSC_OFS_LZ : `AIS_RST_VSC_OFS_ZB;
  localparam [15:0] VSC_GAIN_RST = LIVE_ZERO ? `AIS_RST_VSC_GAIN_LZ : `AIS_RST_VSC_GAIN_ZB;

  // Configuration registers
  reg [15:0] feature_config_reg; // Stage enables and output format
  reg [15:0] vendor_comp_offset_reg; // Compensation offset
  reg [15:0] vendor_comp_gain_reg; // Compensation gain
  reg [15:0] vendor_scale_offset_reg; // Vendor line offset
  reg [15:0] vendor_scale_gain_reg; // Vendor line gain
  reg [15:0] user_scale_offset_reg; // User line offset
  reg [15:0] user_scale_gain_reg; // User line gain

  // Sequencer state
  reg [4:0] state; // Current step
  reg [4:0] next_state; // Step after this edge
  reg [`AIS_CHW-1:0] cur_ch; // Channel being processed
  reg [`AIS_ADCW-1:0] cur_raw; // Captured raw sample
  reg sat_seen; // Any stage clamped this sample
  reg sat_any; // Sticky clamp indicator for software
  reg [`AIS_CHW-1:0] last_ch; // Last channel written

  // Shared stage operands and result
  reg [1:0] mac_op;
  reg [15:0] mac_x;
  reg [15:0] mac_a;
  reg [15:0] mac_b;
  wire signed [15:0] mac_y;
  wire mac_sat;

  // Formatting
  wire [1:0] fmt_sel;
  reg [15:0] fmt_word;
  wire [15:0] mag;
  wire [23:0] rd_word;
  wire samp_take;

  assign fmt_sel = feature_config_reg[`AIS_FEAT_FMT_HI:`AIS_FEAT_FMT_LO];
  assign samp_take = samp_valid_i & samp_ready_o;
  assign mag = mac_y[15] ? (16'h0000 - mac_y) : mac_y;

  // Next-state logic for the time-multiplexed datapath
  always @* begin
    case (state)
      ST_IDLE: next_state = samp_take ? ST_COMP : ST_IDLE;
      ST_COMP: next_state = ST_VEND;
      ST_VEND: next_state = ST_USER;
      ST_USER: next_state = ST_WR;
      ST_WR: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Operand select: COMP and each enabled scaling state feed one line equation to the shared stage; other states pass
  always @* begin
    mac_op = `AIS_OP_PASS;
    mac_x = mac_y;
    mac_a = 16'h0000;
    mac_b = 16'h0000;
    case (state)
      ST_COMP: begin
        // Raw sample enters as a positive 12-bit value
        mac_op = `AIS_OP_PRE;
        mac_x = {4'h0, cur_raw};
        mac_a = vendor_comp_gain_reg;
        mac_b = vendor_comp_offset_reg;
      end
      ST_VEND: begin
        if (feature_config_reg[`AIS_FEAT_VEN]) begin
          mac_op = `AIS_OP_POST;
          mac_a = vendor_scale_gain_reg;
          mac_b = vendor_scale_offset_reg;
        end
      end
      ST_USER: begin
        // Input is vendor result when enabled, else the compensated value
        if (feature_config_reg[`AIS_FEAT_UEN]) begin
          mac_op = `AIS_OP_POST;
          mac_a = user_scale_gain_reg;
          mac_b = user_scale_offset_reg;
        end
      end
      default: begin
        mac_op = `AIS_OP_PASS;
      end
    endcase
  end

  // Shared arithmetic stage
  ais_mac u_mac (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .op_i(mac_op),
    .x_i(mac_x),
    .a_i(mac_a),
    .b_i(mac_b),
    .y_o(mac_y),
    .sat_o(mac_sat)
  );

  // Output representation chosen by the feature register
  always @* begin
    case (fmt_sel)
      `AIS_FMT_SIGNMAG: begin
        // -32768 has no magnitude form; clamp it to the largest one
        fmt_word = (mac_y == 16'sh8000) ? 16'hffff : {mac_y[15], mag[14:0]};
      end
      `AIS_FMT_ALT: fmt_word = {~mac_y[15], mac_y[14:0]};
      default: fmt_word = mac_y;
    endcase
  end

  // Sequencer registers and sample capture
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      samp_ready_o <= 1'b1;
      cur_ch <= 3'h0;
      cur_raw <= 12'h000;
      sat_seen <= 1'b0;
      sat_any <= 1'b0;
      last_ch <= 3'h0;
    end else begin
      state <= next_state;
      // Ready only in idle, so a new sample waits until the word is stored
      samp_ready_o <= (next_state == ST_IDLE);
      if (samp_take) begin
        cur_ch <= samp_ch_i;
        cur_raw <= samp_data_i;
      end
      // Clamps from each stage accumulate into the channel status
      if (state == ST_COMP) begin
        sat_seen <= 1'b0;
      end else if (state != ST_IDLE && mac_sat) begin
        sat_seen <= 1'b1;
      end
      if (state == ST_WR) begin
        last_ch <= cur_ch;
      end
      // Set wins over a clear in the same cycle
      if (state == ST_WR && (sat_seen | mac_sat)) begin
        sat_any <= 1'b1;
      end else if (reg_rd_i && reg_addr_i == `AIS_OFS_STATUS) begin
        sat_any <= 1'b0;
      end
    end
  end

  // Per-channel process data store
  ais_ram u_ram (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .wr_i(state == ST_WR),
    .wr_ch_i(cur_ch),
    .wr_word_i({7'h00, sat_seen | mac_sat, fmt_word}),
    .rd_i(pd_rd_i),
    .rd_ch_i(pd_ch_i),
    .rd_word_o(rd_word)
  );

  // Word and status byte come from the store's output register
  assign pd_data_o = rd_word[15:0];
  assign pd_status_o = rd_word[23:16];

  // Register writes
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      feature_config_reg <= `AIS_RST_FEATURE;
      vendor_comp_offset_reg <= `AIS_RST_COMP_OFS;
      vendor_comp_gain_reg <= `AIS_RST_GAIN_ONE;
      vendor_scale_offset_reg <= VSC_OFS_RST;
      vendor_scale_gain_reg <= VSC_GAIN_RST;
      user_scale_offset_reg <= `AIS_RST_USC_OFS;
      user_scale_gain_reg <= `AIS_RST_GAIN_ONE;
    end else if (reg_wr_i) begin
      // Writes take effect at the next stage that reads them
      case (reg_addr_i)
        `AIS_OFS_FEATURE: feature_config_reg <= reg_wdata_i;
        `AIS_OFS_COMP_OFS: vendor_comp_offset_reg <= reg_wdata_i;
        `AIS_OFS_COMP_GAIN: vendor_comp_gain_reg <= reg_wdata_i;
        `AIS_OFS_VSC_OFS: vendor_scale_offset_reg <= reg_wdata_i;
        `AIS_OFS_VSC_GAIN: vendor_scale_gain_reg <= reg_wdata_i;
        `AIS_OFS_USC_OFS: user_scale_offset_reg <= reg_wdata_i;
        `AIS_OFS_USC_GAIN: user_scale_gain_reg <= reg_wdata_i;
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Register reads: data in the cycle after the strobe, zero otherwise
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `AIS_OFS_STATUS: reg_rdata_o <= {11'h000, sat_any, last_ch, ~samp_ready_o};
        `AIS_OFS_FEATURE: reg_rdata_o <= feature_config_reg;
        `AIS_OFS_COMP_OFS: reg_rdata_o <= vendor_comp_offset_reg;
        `AIS_OFS_COMP_GAIN: reg_rdata_o <= vendor_comp_gain_reg;
        `AIS_OFS_VSC_OFS: reg_rdata_o <= vendor_scale_offset_reg;
        `AIS_OFS_VSC_GAIN: reg_rdata_o <= vendor_scale_gain_reg;
        `AIS_OFS_USC_OFS: reg_rdata_o <= user_scale_offset_reg;
        `AIS_OFS_USC_GAIN: reg_rdata_o <= user_scale_gain_reg;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule // ais_core

`default_nettype wire

// *** sim/ais_core_chk.sv ***
/*
  Port checker for ais_core: sample pacing, register read timing, process data hold.
  Assumes it is bound to ais_core, one clock, reset asynchronous and active low.
*/
`include "ais_map.vh"
`default_nettype none
module ais_core_chk (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Samples
  input wire logic samp_valid_i,
  input wire logic [`AIS_CHW-1:0] samp_ch_i,
  input wire logic [`AIS_ADCW-1:0] samp_data_i,
  input wire logic samp_ready_o,
  // Process data
  input wire logic pd_rd_i,
  input wire logic [`AIS_CHW-1:0] pd_ch_i,
  input wire logic [`AIS_DW-1:0] pd_data_o,
  input wire logic [`AIS_STW-1:0] pd_status_o,
  // Registers
  input wire logic [`AIS_AW-1:0] reg_addr_i,
  input wire logic [`AIS_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`AIS_DW-1:0] reg_rdata_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  take_busy_a:
    assert property (samp_valid_i && samp_ready_o |=> !samp_ready_o [*4] ##1 samp_ready_o)
    else $error("ready not low for four cycles after a take");
  idle_ready_a:
    assert property (samp_ready_o && !samp_valid_i |=> samp_ready_o)
    else $error("ready dropped with no sample taken");
  rdata_idle_a:
    assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  gain_readback_a:
    assert property (reg_wr_i && reg_addr_i == `AIS_OFS_COMP_GAIN ##2 reg_rd_i
      && reg_addr_i == `AIS_OFS_COMP_GAIN |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("gain register did not read back");
  pd_hold_a:
    assert property (!pd_rd_i |=> $stable(pd_data_o) && $stable(pd_status_o))
    else $error("process data changed without a read");
  status_pad_a:
    assert property (pd_status_o[7:1] == 7'h00)
    else $error("status byte spare bits set");
  clamp_value_a:
    assert property (pd_status_o[0] |-> pd_data_o inside {16'h7fff, 16'h8000, 16'hffff, 16'h0000})
    else $error("clamp flag without a limit value");
  busy_flag_a:
    assert property (reg_rd_i && reg_addr_i == `AIS_OFS_STATUS |=> reg_rdata_o[0] == !$past(samp_ready_o))
    else $error("busy bit disagrees with ready");
endmodule // ais_core_chk
bind ais_core ais_core_chk ais_core_chk_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .samp_valid_i(samp_valid_i), .samp_ch_i(samp_ch_i), .samp_data_i(samp_data_i),
  .samp_ready_o(samp_ready_o), .pd_rd_i(pd_rd_i), .pd_ch_i(pd_ch_i), .pd_data_o(pd_data_o),
  .pd_status_o(pd_status_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

// *** sim/ais_coupler.sv ***
/*
  Bus coupler model: reads one channel's word and status byte per request.
  Assumes the block answers in the cycle after the strobe.
*/
`include "ais_map.vh"
`default_nettype none
module ais_coupler (
  // Clock
  input wire logic ref_clk_i,
  // Read request
  output logic pd_rd_o,
  output logic [`AIS_CHW-1:0] pd_ch_o,
  // Answer
  input wire logic [`AIS_DW-1:0] pd_data_i,
  input wire logic [`AIS_STW-1:0] pd_status_i
);
  // Idle at time zero
  initial begin
    pd_rd_o = 1'b0;
    pd_ch_o = 3'h0;
  end
  // One strobe, then word and status taken together a cycle later
  task automatic fetch(input logic [2:0] ch, output logic [15:0] d, output logic [7:0] s);
    pd_rd_o <= 1'b1;
    pd_ch_o <= ch;
    @(posedge ref_clk_i);
    pd_rd_o <= 1'b0;
    pd_ch_o <= ~ch; // Released select must not look like a stale request
    @(posedge ref_clk_i);
    d = pd_data_i;
    s = pd_status_i;
  endtask
endmodule // ais_coupler
`default_nettype wire

// *** sim/ais_core_bench.sv ***
/*
  Self-checking bench for ais_core: scaling rows, registers, back-to-back samples, reset.
  Assumes ais_core, the coupler model and the bound checker.
*/
`include "ais_map.vh"
`default_nettype none
module ais_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // Row: enables and output format, coefficients, sample, expected word and clamp flag
  typedef struct packed {
    logic [3:0] feat;
    logic [15:0] co, cg, vo, vg, uo, ug;
    logic [11:0] samp;
    logic [15:0] exp;
    logic st;
  } ais_row_t;
  ais_row_t rows [12] = '{
    {4'h1, 96'h0000_0800_0000_4004_0000_0800, 12'hfff, 16'h7fff, 1'b0},
    {4'h1, 96'h0000_0800_0000_4004_0000_0800, 12'h000, 16'h0000, 1'b0},
    {4'h1, 96'h0000_0800_0000_4004_0000_0800, 12'h7ff, 16'h3ffb, 1'b0},
    {4'h0, 96'h0010_1000_0000_4004_0000_0800, 12'h100, 16'h0220, 1'b0},
    {4'h2, 96'h0000_0800_1000_4004_0064_0400, 12'h200, 16'h0164, 1'b0},
    {4'h3, 96'h0000_0800_0010_1000_fff8_1800, 12'h010, 16'h0088, 1'b0},
    {4'h1, 96'h0000_0800_0000_7fff_0000_0800, 12'hfff, 16'h7fff, 1'b1},
    {4'h1, 96'h0000_0800_ffff_0800_0000_0800, 12'h000, 16'hffff, 1'b0},
    {4'h1, 96'h0000_0800_fc00_0800_0000_0800, 12'h000, 16'hfc00, 1'b0},
    {4'h5, 96'h0000_0800_fc00_0800_0000_0800, 12'h000, 16'h8400, 1'b0},
    {4'h9, 96'h0000_0800_fc00_0800_0000_0800, 12'h000, 16'h7c00, 1'b0},
    {4'h1, 96'h0000_0800_8000_ffff_0000_0800, 12'hfff, 16'h8000, 1'b1}};
  logic ref_clk_i = 1'b0;
  logic rst_b_i, samp_valid_i, samp_ready_o, pd_rd_i, reg_wr_i, reg_rd_i;
  logic [2:0] samp_ch_i, pd_ch_i;
  logic [11:0] samp_data_i;
  logic [15:0] pd_data_o, reg_wdata_i, reg_rdata_o;
  logic [7:0] pd_status_o;
  logic [5:0] reg_addr_i;
  int errors = 0;
  int checked = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  ais_core #(.LIVE_ZERO(0)) ais_core_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .samp_valid_i(samp_valid_i), .samp_ch_i(samp_ch_i), .samp_data_i(samp_data_i),
    .samp_ready_o(samp_ready_o), .pd_rd_i(pd_rd_i), .pd_ch_i(pd_ch_i), .pd_data_o(pd_data_o),
    .pd_status_o(pd_status_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  ais_coupler ais_coupler_inst (.ref_clk_i(ref_clk_i), .pd_rd_o(pd_rd_i), .pd_ch_o(pd_ch_i),
    .pd_data_i(pd_data_o), .pd_status_i(pd_status_o));
  // Register write; the idle cycle after it keeps strobes from being set twice in one step
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // Register read; data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    // Take the data once they have settled after the launching edge
    #1 v = reg_rdata_o;
    @(posedge ref_clk_i);
  endtask
  // Offer a sample and hold it until taken; caller drops valid
  task automatic put(input logic [2:0] ch, input logic [11:0] v);
    int n;
    logic took;
    samp_ch_i <= ch;
    samp_data_i <= v;
    samp_valid_i <= 1'b1;
    n = 0;
    // Ready is registered, so its mid-cycle value is what the next edge sees
    do begin
      @(negedge ref_clk_i);
      took = (samp_ready_o === 1'b1);
      @(posedge ref_clk_i);
      n++;
    end while (!took && n < 20);
  endtask
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    results();
  end
  // Main sequence
  initial begin
    ais_row_t r;
    logic [15:0] d;
    logic [7:0] s;
    rst_b_i = 1'b0;
    {samp_valid_i, reg_wr_i, reg_rd_i, samp_ch_i, samp_data_i} = '0;
    {reg_addr_i, reg_wdata_i} = '0;
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      wr(`AIS_OFS_FEATURE, {12'h000, r.feat});
      wr(`AIS_OFS_COMP_OFS, r.co);
      wr(`AIS_OFS_COMP_GAIN, r.cg);
      wr(`AIS_OFS_VSC_OFS, r.vo);
      wr(`AIS_OFS_VSC_GAIN, r.vg);
      wr(`AIS_OFS_USC_OFS, r.uo);
      wr(`AIS_OFS_USC_GAIN, r.ug);
      put(i[2:0], r.samp);
      samp_valid_i <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      ais_coupler_inst.fetch(i[2:0], d, s);
      chk16("data", r.exp, d);
      chk8("status", {7'h00, r.st}, s);
      $display("row %0d done", i);
    end
    // Readback and an unmapped index
    wr(`AIS_OFS_COMP_GAIN, 16'h1234);
    rd(`AIS_OFS_COMP_GAIN, d);
    chk16("comp gain", 16'h1234, d);
    rd(6'h3f, d);
    chk16("unmapped", 16'h0000, d);
    $display("readback done");
    // Two samples back to back; the second waits while the stage is busy
    wr(`AIS_OFS_COMP_GAIN, 16'h0800);
    wr(`AIS_OFS_VSC_OFS, 16'h0000);
    wr(`AIS_OFS_VSC_GAIN, 16'h0800);
    put(3'h6, 12'h123);
    put(3'h7, 12'h456);
    samp_valid_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    ais_coupler_inst.fetch(3'h6, d, s);
    chk16("ch6", 16'h0123, d);
    ais_coupler_inst.fetch(3'h7, d, s);
    chk16("ch7", 16'h0456, d);
    $display("back to back done");
    // Reset in mid-run restores the default scaling
    rst_b_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk16("pd in reset", 16'h0000, pd_data_o);
    rst_b_i <= 1'b1;
    rd(`AIS_OFS_FEATURE, d);
    chk16("feature", `AIS_RST_FEATURE, d);
    rd(`AIS_OFS_COMP_GAIN, d);
    chk16("comp gain", `AIS_RST_GAIN_ONE, d);
    rd(`AIS_OFS_VSC_GAIN, d);
    chk16("vend gain", `AIS_RST_VSC_GAIN_ZB, d);
    rd(`AIS_OFS_STATUS, d);
    chk16("status", 16'h0000, d);
    $display("reset done");
    results();
  end
endmodule // ais_core_bench
`default_nettype wire
